// *** core/ior_pkg.sv ***
// shared constants for the sensor output and command register bank
package ior_pkg;

  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned DEC_W      = 5;
  localparam int unsigned TEMP_W     = 12;
  localparam int unsigned SERIAL_W   = 12;
  localparam int unsigned MAG_LOW_W  = 4;
  localparam int unsigned FUNC_N     = 4;

  // byte offsets of the low byte of each register
  localparam logic [6:0] OFS_MAG_X_FIELD   = 7'h10;
  localparam logic [6:0] OFS_MAG_Y_FIELD   = 7'h12;
  localparam logic [6:0] OFS_MAG_Z_FIELD   = 7'h14;
  localparam logic [6:0] OFS_PRESSURE      = 7'h16;
  localparam logic [6:0] OFS_TEMPERATURE   = 7'h18;
  localparam logic [6:0] OFS_GLOBAL_TRIG   = 7'h3E;
  localparam logic [6:0] OFS_LOT_CODE_LOW  = 7'h52;
  localparam logic [6:0] OFS_LOT_CODE_HIGH = 7'h54;
  localparam logic [6:0] OFS_PART_IDENTITY = 7'h56;
  localparam logic [6:0] OFS_UNIT_SERIAL   = 7'h58;

  // trigger bit positions inside the global trigger register
  localparam int unsigned TRIG_SOFT_RESET  = 7;
  localparam int unsigned TRIG_FLASH_SAVE  = 3;
  localparam int unsigned TRIG_FACTORY     = 1;
  localparam int unsigned TRIG_BIAS        = 0;

  // internal function index used by the command sequencer
  localparam logic [1:0] FN_BIAS    = 2'h0;
  localparam logic [1:0] FN_FACTORY = 2'h1;
  localparam logic [1:0] FN_FLASH   = 2'h2;
  localparam logic [1:0] FN_RESET   = 2'h3;

  localparam logic [15:0] RST_DATA          = 16'h0000;
  localparam logic [15:0] RST_GLOBAL_TRIG   = 16'h0000;
  // arbitrary neutral identity defaults
  localparam logic [15:0] DEF_PART_IDENTITY = 16'h1A5C;
  localparam logic [31:0] DEF_LOT_CODE      = 32'h0000_0001;
  localparam logic [11:0] DEF_UNIT_SERIAL   = 12'h001;

  typedef enum logic [1:0] {
    IOR_IDLE,
    IOR_RUN,
    IOR_RELOAD
  } ior_seq_e;

  // pick the next pending function: reset first, then calibration, flash last
  function automatic logic [1:0] ior_pick_next(input logic [3:0] pend);
    logic [1:0] sel;
    sel = FN_BIAS;
    if (pend[FN_RESET]) begin
      sel = FN_RESET;
    end else if (pend[FN_BIAS]) begin
      sel = FN_BIAS;
    end else if (pend[FN_FACTORY]) begin
      sel = FN_FACTORY;
    end else if (pend[FN_FLASH]) begin
      sel = FN_FLASH;
    end
    return sel;
  endfunction : ior_pick_next

  // true when a byte address falls on the given 16-bit register
  function automatic logic ior_hit(input logic [6:0] addr, input logic [6:0] ofs);
    return addr[6:1] == ofs[6:1];
  endfunction : ior_hit

endpackage : ior_pkg

// *** core/ior_mag_trim.sv ***
// clears the magnetometer low bits that the decimation setting leaves inactive
module ior_mag_trim
  import ior_pkg::*;
(
  input  wire logic [15:0]      raw_i,
  input  wire logic [DEC_W-1:0] decim_i,
  output logic      [15:0]      trim_o
);

  logic [MAG_LOW_W-1:0] low_mask;

  always_comb begin
    low_mask = '0;
    for (int i = 0; i < MAG_LOW_W; i++) begin
      // bit i is active once the decimation setting exceeds 3-i
      if (int'(decim_i) >= MAG_LOW_W - i) begin
        low_mask[i] = 1'b1;
      end
    end
    trim_o = {raw_i[15:MAG_LOW_W], raw_i[MAG_LOW_W-1:0] & low_mask};
  end

endmodule : ior_mag_trim

// *** core/ior_cmd_seq.sv ***
// runs global trigger functions one at a time and clears each when it completes
module ior_cmd_seq
  import ior_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic [FUNC_N-1:0] trig_set_i,
  input  wire logic [FUNC_N-1:0] func_done_i,
  input  wire logic              reload_done_i,
  output logic      [FUNC_N-1:0] func_start_o,
  output logic                   reload_start_o,
  output logic                   busy_o,
  output logic      [FUNC_N-1:0] pending_o
);

  ior_seq_e          state;
  ior_seq_e          next_state;
  logic [1:0]        cur;
  logic [1:0]        next_cur;
  logic [FUNC_N-1:0] pend;
  logic [FUNC_N-1:0] next_pend;
  logic [FUNC_N-1:0] next_func_start;
  logic              next_reload_start;

  always_comb begin
    next_state        = state;
    next_cur          = cur;
    next_func_start   = '0;
    next_reload_start = 1'b0;
    next_pend         = pend;
    case (state)
      IOR_IDLE: begin
        if (pend != '0) begin
          next_cur                              = ior_pick_next(pend);
          next_func_start[ior_pick_next(pend)] = 1'b1;
          next_state                            = IOR_RUN;
        end
      end
      IOR_RUN: begin
        if (func_done_i[cur]) begin
          next_pend[cur] = 1'b0;
          // new output data waits until control settings come back from flash
          if (cur == FN_FLASH || cur == FN_RESET) begin
            next_reload_start = 1'b1;
            next_state        = IOR_RELOAD;
          end else begin
            next_state = IOR_IDLE;
          end
        end
      end
      IOR_RELOAD: begin
        if (reload_done_i) begin
          next_state = IOR_IDLE;
        end
      end
      default: begin
        next_state = IOR_IDLE;
      end
    endcase
    // a fresh write wins over the completion clear
    next_pend = next_pend | trig_set_i;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state          <= IOR_IDLE;
      cur            <= FN_BIAS;
      pend           <= '0;
      func_start_o   <= '0;
      reload_start_o <= 1'b0;
    end else begin
      state          <= next_state;
      cur            <= next_cur;
      pend           <= next_pend;
      func_start_o   <= next_func_start;
      reload_start_o <= next_reload_start;
    end
  end

  assign busy_o    = (state != IOR_IDLE) || (pend != '0);
  assign pending_o = pend;

endmodule : ior_cmd_seq

// *** core/ior_regs.sv ***
// magnetometer, pressure, temperature, global trigger and identity register bank
//
// Notes on behaviour
// - With no decimation the four low bits of every magnetometer register read as zero.
// - The number of active low magnetometer bits equals the decimation setting, up to four.
// - The three magnetometer registers hold signed 16-bit field values, with inactive low bits cleared by the decimation setting.
// - The pressure register holds an unsigned 16-bit value, passed through unchanged.
// - The temperature register holds a 12-bit signed reading in bits 11:0, upper bits zero.
// - A trigger bit written as one stays set until its function reports completion.
// - Bit 7 of the trigger register starts a software reset.
// - Bit 3 of the trigger register starts a copy of the user registers into flash.
// - After a flash copy or reset, control settings reload before outputs update again.
// - The trigger register reads as zero; bit 1 restores factory calibration, bit 0 corrects bias.
// - The part identity register always returns a fixed 16-bit code.
// - Two read-only registers together give a 32-bit lot code, low half first.
// - The serial register holds a 12-bit number in bits 11:0 with bits 15:12 zero.
// - Writes arrive one byte at a time; even address is bits 7:0, odd is bits 15:8.
// - The new-data flag rises on a magnetometer/pressure update and falls on a read of them.
module ior_regs
  import ior_pkg::*;
#(
  parameter logic [15:0]       PART_IDENTITY = DEF_PART_IDENTITY,
  parameter logic [31:0]       LOT_CODE      = DEF_LOT_CODE,
  parameter logic [SERIAL_W-1:0] UNIT_SERIAL = DEF_UNIT_SERIAL
) (
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [ADDR_W-1:0]   reg_addr_i,
  input  wire logic [BYTE_W-1:0]   reg_wdata_i,
  output logic      [DATA_W-1:0]   rd_data_o,
  output logic                     rd_valid_o,
  input  wire logic [15:0]         mag_x_i,
  input  wire logic [15:0]         mag_y_i,
  input  wire logic [15:0]         mag_z_i,
  input  wire logic [15:0]         baro_i,
  input  wire logic                mag_baro_upd_i,
  input  wire logic [TEMP_W-1:0]   temp_i,
  input  wire logic                temp_upd_i,
  input  wire logic [DEC_W-1:0]    decim_i,
  input  wire logic [FUNC_N-1:0]   func_done_i,
  input  wire logic                reload_done_i,
  output logic                     bias_start_o,
  output logic                     factory_start_o,
  output logic                     flash_start_o,
  output logic                     soft_reset_o,
  output logic                     reload_start_o,
  output logic                     cmd_busy_o,
  output logic                     new_mag_baro_o
);

  // output data registers
  logic [15:0]       mag_x_field;
  logic [15:0]       mag_y_field;
  logic [15:0]       mag_z_field;
  logic [15:0]       pressure_value;
  logic [15:0]       internal_temperature;
  logic [15:0]       next_mag_x_field;
  logic [15:0]       next_mag_y_field;
  logic [15:0]       next_mag_z_field;
  logic [15:0]       next_pressure_value;
  logic [15:0]       next_internal_temperature;

  // read port and flags
  logic [15:0]       next_rd_data;
  logic              next_rd_valid;
  logic              next_new_mag_baro;
  logic              next_cmd_busy;

  // command path
  logic [FUNC_N-1:0] trig_set;
  logic [FUNC_N-1:0] seq_start;
  logic              seq_reload;
  logic              seq_busy;
  logic [15:0]       mag_x_trim;
  logic [15:0]       mag_y_trim;
  logic [15:0]       mag_z_trim;
  logic              mag_read;
  logic              hold_out;

  ior_mag_trim u_trim_x (
    .raw_i   (mag_x_i),
    .decim_i (decim_i),
    .trim_o  (mag_x_trim)
  );

  ior_mag_trim u_trim_y (
    .raw_i   (mag_y_i),
    .decim_i (decim_i),
    .trim_o  (mag_y_trim)
  );

  ior_mag_trim u_trim_z (
    .raw_i   (mag_z_i),
    .decim_i (decim_i),
    .trim_o  (mag_z_trim)
  );

  // trigger register write decode: only the low byte carries function bits
  always_comb begin
    trig_set = '0;
    if (reg_wr_i && reg_addr_i == OFS_GLOBAL_TRIG) begin
      trig_set[FN_RESET]   = reg_wdata_i[TRIG_SOFT_RESET];
      trig_set[FN_FLASH]   = reg_wdata_i[TRIG_FLASH_SAVE];
      trig_set[FN_FACTORY] = reg_wdata_i[TRIG_FACTORY];
      trig_set[FN_BIAS]    = reg_wdata_i[TRIG_BIAS];
    end
  end

  ior_cmd_seq u_seq (
    .core_clk_i     (core_clk_i),
    .resetn_i       (resetn_i),
    .trig_set_i     (trig_set),
    .func_done_i    (func_done_i),
    .reload_done_i  (reload_done_i),
    .func_start_o   (seq_start),
    .reload_start_o (seq_reload),
    .busy_o         (seq_busy),
    .pending_o      ()
  );

  // output data freezes while a global function or reload is in progress
  assign hold_out = seq_busy;

  always_comb begin
    next_mag_x_field          = mag_x_field;
    next_mag_y_field          = mag_y_field;
    next_mag_z_field          = mag_z_field;
    next_pressure_value       = pressure_value;
    next_internal_temperature = internal_temperature;
    if (mag_baro_upd_i && !hold_out) begin
      next_mag_x_field    = mag_x_trim;
      next_mag_y_field    = mag_y_trim;
      next_mag_z_field    = mag_z_trim;
      next_pressure_value = baro_i;
    end
    if (temp_upd_i && !hold_out) begin
      next_internal_temperature = {{(DATA_W-TEMP_W){1'b0}}, temp_i};
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mag_x_field          <= RST_DATA;
      mag_y_field          <= RST_DATA;
      mag_z_field          <= RST_DATA;
      pressure_value       <= RST_DATA;
      internal_temperature <= RST_DATA;
    end else begin
      mag_x_field          <= next_mag_x_field;
      mag_y_field          <= next_mag_y_field;
      mag_z_field          <= next_mag_z_field;
      pressure_value       <= next_pressure_value;
      internal_temperature <= next_internal_temperature;
    end
  end

  // read decode; a write to any of these addresses except the trigger register is simply dropped
  always_comb begin
    next_rd_data  = 16'h0000;
    next_rd_valid = reg_rd_i;
    mag_read      = 1'b0;
    if (reg_rd_i) begin
      if (ior_hit(reg_addr_i, OFS_MAG_X_FIELD)) begin
        next_rd_data = mag_x_field;
        mag_read     = 1'b1;
      end else if (ior_hit(reg_addr_i, OFS_MAG_Y_FIELD)) begin
        next_rd_data = mag_y_field;
        mag_read     = 1'b1;
      end else if (ior_hit(reg_addr_i, OFS_MAG_Z_FIELD)) begin
        next_rd_data = mag_z_field;
        mag_read     = 1'b1;
      end else if (ior_hit(reg_addr_i, OFS_PRESSURE)) begin
        next_rd_data = pressure_value;
        mag_read     = 1'b1;
      end else if (ior_hit(reg_addr_i, OFS_TEMPERATURE)) begin
        next_rd_data = internal_temperature;
      end else if (ior_hit(reg_addr_i, OFS_GLOBAL_TRIG)) begin
        next_rd_data = RST_GLOBAL_TRIG;
      end else if (ior_hit(reg_addr_i, OFS_LOT_CODE_LOW)) begin
        next_rd_data = LOT_CODE[15:0];
      end else if (ior_hit(reg_addr_i, OFS_LOT_CODE_HIGH)) begin
        next_rd_data = LOT_CODE[31:16];
      end else if (ior_hit(reg_addr_i, OFS_PART_IDENTITY)) begin
        next_rd_data = PART_IDENTITY;
      end else if (ior_hit(reg_addr_i, OFS_UNIT_SERIAL)) begin
        next_rd_data = {{(DATA_W-SERIAL_W){1'b0}}, UNIT_SERIAL};
      end
    end
    // writes to output and identity registers never reach any storage
    if (reg_wr_i) begin
      next_rd_valid = 1'b0;
      next_rd_data  = 16'h0000;
      mag_read      = 1'b0;
    end
  end

  // set wins over the read clear so an update in the read cycle is not lost
  always_comb begin
    next_new_mag_baro = new_mag_baro_o;
    if (mag_read) begin
      next_new_mag_baro = 1'b0;
    end
    if (mag_baro_upd_i && !hold_out) begin
      next_new_mag_baro = 1'b1;
    end
    next_cmd_busy = seq_busy | (trig_set != '0);
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o      <= 16'h0000;
      rd_valid_o     <= 1'b0;
      new_mag_baro_o <= 1'b0;
      cmd_busy_o     <= 1'b0;
    end else begin
      rd_data_o      <= next_rd_data;
      rd_valid_o     <= next_rd_valid;
      new_mag_baro_o <= next_new_mag_baro;
      cmd_busy_o     <= next_cmd_busy;
    end
  end

  // start strobes come straight from the sequencer's flip-flops
  assign bias_start_o    = seq_start[FN_BIAS];
  assign factory_start_o = seq_start[FN_FACTORY];
  assign flash_start_o   = seq_start[FN_FLASH];
  assign soft_reset_o    = seq_start[FN_RESET];
  assign reload_start_o  = seq_reload;

endmodule : ior_regs

// *** test/ior_regs_properties.sv ***
// concurrent checks on the register bank ports
module ior_regs_properties
  import ior_pkg::*;
#(
  parameter logic [15:0] PART_IDENTITY = DEF_PART_IDENTITY,
  parameter logic [11:0] UNIT_SERIAL   = DEF_UNIT_SERIAL
) (
  input wire logic              core_clk_i,
  input wire logic              resetn_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [BYTE_W-1:0] reg_wdata_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic              rd_valid_o,
  input wire logic              mag_baro_upd_i,
  input wire logic [FUNC_N-1:0] func_done_i,
  input wire logic              flash_start_o,
  input wire logic              soft_reset_o,
  input wire logic              reload_start_o,
  input wire logic              cmd_busy_o,
  input wire logic              new_mag_baro_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  logic rd_ok;
  logic trig;
  assign rd_ok = reg_rd_i && !reg_wr_i;
  assign trig  = reg_wr_i && reg_addr_i == OFS_GLOBAL_TRIG && (reg_wdata_i & 8'h8B) != 8'h00;

  chk_read_answer: assert property (rd_ok |=> rd_valid_o)
    else $error("read not answered");
  chk_read_clash: assert property (reg_rd_i && reg_wr_i |=> !rd_valid_o)
    else $error("read beside write answered");
  chk_data_idle: assert property (!rd_valid_o |-> rd_data_o == 16'h0000)
    else $error("read data not idle");
  chk_part_code: assert property (rd_ok && reg_addr_i[6:1] == OFS_PART_IDENTITY[6:1]
    |=> rd_data_o == PART_IDENTITY) else $error("part code wrong");
  chk_serial_field: assert property (rd_ok && reg_addr_i[6:1] == OFS_UNIT_SERIAL[6:1]
    |=> rd_data_o == {4'h0, UNIT_SERIAL}) else $error("serial wrong");
  chk_trig_wo: assert property (rd_ok && reg_addr_i[6:1] == OFS_GLOBAL_TRIG[6:1]
    |=> rd_data_o == 16'h0000) else $error("trigger readable");
  chk_trig_busy: assert property (trig |=> cmd_busy_o)
    else $error("trigger not pending");
  chk_unused_bits: assert property (reg_wr_i && !trig && !cmd_busy_o |=> !cmd_busy_o)
    else $error("unused write started work");
  chk_flash_start: assert property (trig && reg_wdata_i == 8'h08 && !cmd_busy_o
    |=> ##1 flash_start_o) else $error("flash copy not started");
  chk_reset_first: assert property (trig && reg_wdata_i[7] && !cmd_busy_o
    |=> ##1 soft_reset_o) else $error("soft reset not started");
  chk_reload_cause: assert property (reload_start_o |-> $past(func_done_i[2]) || $past(func_done_i[3]))
    else $error("reload without cause");
  chk_flag_rise: assert property (mag_baro_upd_i && !cmd_busy_o && !reg_wr_i && !$past(reg_wr_i)
    |=> new_mag_baro_o) else $error("new data flag low");
  chk_flag_fall: assert property (rd_ok && reg_addr_i[6:3] == 4'h2 && !mag_baro_upd_i
    |=> !new_mag_baro_o) else $error("new data flag kept");
endmodule : ior_regs_properties

// *** test/ior_func_model.sv ***
// completes trigger functions and the reload step after a set latency
module ior_func_model (
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] start_i,
  input  wire logic       reload_start_i,
  input  wire logic [7:0] lat_i,
  output logic      [3:0] done_o,
  output logic            reload_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] act;
  logic       rl_act;
  logic [7:0] cnt;
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act <= 4'h0;
      rl_act <= 1'b0;
      cnt <= 8'h00;
      done_o <= 4'h0;
      reload_done_o <= 1'b0;
    end else begin
      done_o <= 4'h0;
      reload_done_o <= 1'b0;
      if (start_i != 4'h0 || reload_start_i) begin
        act <= start_i;
        rl_act <= reload_start_i;
        cnt <= lat_i;
      end else if (act != 4'h0 || rl_act) begin
        // completion lets the trigger bit clear itself
        if (cnt == 8'h00) begin
          done_o <= act;
          reload_done_o <= rl_act;
          act <= 4'h0;
          rl_act <= 1'b0;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule : ior_func_model

// *** test/tb_top.sv ***
// top testbench: register reads, sensor updates and trigger sequencing
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
  import ior_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // identity values are arbitrary; serial sits one below its top 12-bit value
  localparam logic [15:0] PID = 16'h2B7D;
  localparam logic [31:0] LOT = 32'h89AB_CDEF;
  localparam logic [11:0] SER = 12'hFFE;
  logic        clk = 1'b0, rstn = 1'b0, wr, rd, rv, upd, rdn, rl, busy, nf;
  logic [6:0]  addr;
  logic [7:0]  wd, lat, eb;
  logic [15:0] rdata, mx, my, mz, bar, msk;
  logic [11:0] tmp;
  logic [4:0]  dec;
  logic [3:0]  done, st, e4;
  int          errors = 0, checks_done = 0, rcnt, scnt[4];
  int          dv[6] = '{0, 1, 2, 3, 4, 31};
  logic [6:0]  ta[7] = '{7'h3E, 7'h3E, 7'h3E, 7'h3E, 7'h3E, 7'h3E, 7'h3F};
  logic [7:0]  td[7] = '{8'h01, 8'h02, 8'h08, 8'h80, 8'h0B, 8'h74, 8'hFF};

  always #4 clk = ~clk;

  ior_regs #(.PART_IDENTITY(PID), .LOT_CODE(LOT), .UNIT_SERIAL(SER)) i_ior_regs (
    .core_clk_i(clk), .resetn_i(rstn), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wd), .rd_data_o(rdata), .rd_valid_o(rv), .mag_x_i(mx), .mag_y_i(my),
    .mag_z_i(mz), .baro_i(bar), .mag_baro_upd_i(upd), .temp_i(tmp), .temp_upd_i(upd),
    .decim_i(dec), .func_done_i(done), .reload_done_i(rdn), .bias_start_o(st[0]),
    .factory_start_o(st[1]), .flash_start_o(st[2]), .soft_reset_o(st[3]),
    .reload_start_o(rl), .cmd_busy_o(busy), .new_mag_baro_o(nf));

  ior_func_model u_func (.core_clk_i(clk), .resetn_i(rstn), .start_i(st),
    .reload_start_i(rl), .lat_i(lat), .done_o(done), .reload_done_o(rdn));

  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) if (st[i]) scnt[i]++;
    if (rl) rcnt++;
  end

  task automatic finish_test;
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // each access starts one edge later so a strobe is never set and cleared at once
  task automatic wr_b(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    wr = 1'b1; addr = a; wd = d;
    @(posedge clk) #1;
    wr = 1'b0;
  endtask : wr_b

  task automatic rd_r(input logic [6:0] a, input logic [15:0] e);
    @(posedge clk) #1;
    rd = 1'b1; addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    `CHK(rv, 1'b1)
    `CHK(rdata, e)
  endtask : rd_r

  task automatic upd_all(input logic [15:0] x);
    @(posedge clk) #1;
    mx = x; my = 16'h800B; mz = 16'h7FFF; bar = 16'hEA60; tmp = 12'hC3E; upd = 1'b1;
    @(posedge clk) #1;
    upd = 1'b0;
  endtask : upd_all

  task automatic wait_idle;
    for (int n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clk) #1;
    if (busy !== 1'b0) begin
      errors++;
      finish_test();
    end
  endtask : wait_idle

  initial begin
    wr = 0; rd = 0; addr = 0; wd = 0; upd = 0; dec = 0; lat = 8'd2;
    mx = 0; my = 0; mz = 0; bar = 0; tmp = 0;
    repeat (12) @(posedge clk);
    #1 rstn = 1'b1;
    rd_r(7'h56, PID);
    rd_r(7'h57, PID);
    rd_r(7'h52, LOT[15:0]);
    rd_r(7'h54, LOT[31:16]);
    rd_r(7'h58, {4'h0, SER});
    rd_r(7'h3E, 16'h0000);
    rd_r(7'h20, 16'h0000);
    wr_b(7'h56, 8'hFF);
    rd_r(7'h56, PID);
    for (int i = 0; i < 6; i++) begin
      dec = dv[i][4:0];
      msk = (dv[i] >= 4) ? 16'hFFFF : 16'hFFFF << (4 - dv[i]);
      upd_all(16'hCC0F);
      `CHK(nf, 1'b1)
      rd_r(7'h18, 16'h0C3E);
      `CHK(nf, 1'b1)
      rd_r(7'h10, 16'hCC0F & msk);
      `CHK(nf, 1'b0)
      rd_r(7'h12, 16'h800B & msk);
      rd_r(7'h14, 16'h7FFF & msk);
      rd_r(7'h16, 16'hEA60);
    end
    wr_b(7'h10, 8'h00);
    wr_b(7'h19, 8'h00);
    rd_r(7'h10, 16'hCC0F);
    rd_r(7'h18, 16'h0C3E);
    for (int k = 0; k < 7; k++) begin
      rcnt = 0;
      scnt = '{0, 0, 0, 0};
      eb = (ta[k] == 7'h3E) ? (td[k] & 8'h8B) : 8'h00;
      e4 = {eb[7], eb[3], eb[1], eb[0]};
      wr_b(ta[k], td[k]);
      wait_idle();
      for (int b = 0; b < 4; b++) `CHK(scnt[b], int'(e4[b]))
      `CHK(rcnt, int'(eb[3] | eb[7]))
    end
    // a slow flash copy: updates in the meantime must not land
    lat = 8'd40;
    wr_b(7'h3E, 8'h08);
    upd_all(16'h1230);
    `CHK(nf, 1'b0)
    wait_idle();
    rd_r(7'h10, 16'hCC0F);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : tb_top

bind ior_regs ior_regs_properties #(.PART_IDENTITY(PART_IDENTITY), .UNIT_SERIAL(UNIT_SERIAL))
  u_chk (.core_clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .rd_data_o, .rd_valid_o, .mag_baro_upd_i, .func_done_i, .flash_start_o, .soft_reset_o,
  .reload_start_o, .cmd_busy_o, .new_mag_baro_o);
